// ### dv/master_model.sv
// Master controller model: sends command frames, collects answers
`timescale 1ns/1ps
module master_model (
    input  wire       clk,         // System clock
    input  wire       slow,        // Long stall after each sent byte
    input  wire [7:0] tx_byte_ff,  // Byte from the handler
    input  wire       tx_valid_ff, // Byte strobe from the handler
    output reg  [7:0] rx_byte,     // Received byte
    output reg        rx_valid,    // Received byte strobe
    output reg        rx_error,    // Line fault in this frame
    output reg        frame_end,   // Idle gap seen
    output reg        tx_ready     // Engine can take a byte
);
    reg [7:0] cmd [0:40];
    reg [7:0] rsp [0:255];
    integer   rsp_n = 0;
    integer   hold  = 0;
    initial begin
        {rx_byte, rx_valid, rx_error, frame_end, tx_ready} = 12'h001;
    end
    ////////////////////////////////////////////////////////////////////////
    // Master opens every exchange, fields in order
    task send(input integer n, input flt);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(posedge clk);
                rx_byte  <= cmd[i];
                rx_valid <= 1'b1;
                rx_error <= flt && (i == 3);
                @(posedge clk);
                rx_byte  <= ~cmd[i]; // Not held past its strobe
                rx_valid <= 1'b0;
                rx_error <= 1'b0;
                repeat (2) @(posedge clk);
            end
            frame_end <= 1'b1;
            @(posedge clk);
            frame_end <= 1'b0;
        end
    endtask
    // A real bit engine is busy for a whole character after each byte
    always @(posedge clk) begin
        if (tx_valid_ff) begin
            rsp[rsp_n] <= tx_byte_ff;
            rsp_n      <= rsp_n + 1;
            tx_ready   <= 1'b0;
            hold       <= slow ? 15 : 1;
        end else if (hold > 0) hold <= hold - 1;
        else tx_ready <= 1'b1;
    end
endmodule // master_model

// ### dv/serial_slave_message_handler_checker.sv
// Port-level assertions for the serial slave message handler
`timescale 1ns/1ps
module serial_slave_message_handler_checker (
    input wire        clk,                            // System clock
    input wire        rst_n,                          // Sync reset
    input wire        transmit_enable_control_select, // RTS mode
    input wire [6:0]  response_wait_time_setting,     // Wait in ms
    input wire        frame_end,                      // Idle gap seen
    input wire        tx_ready,                       // Engine free
    input wire        tx_valid_ff,                    // Byte strobe
    input wire        rts_ff,                         // Transmit enable
    input wire [15:0] reg_addr_ff,                    // Table address
    input wire        reg_wr_ff,                      // Write strobe
    input wire        busy_ff                         // Frame in hand
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire       sel = transmit_enable_control_select;
    reg [23:0] gap_ff; // Saturates so a long idle never wraps to zero
    always @(posedge clk) begin
        if (!rst_n || frame_end) gap_ff <= 24'h0;
        else if (gap_ff != 24'hffffff) gap_ff <= gap_ff + 24'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    AST_BUSY_TX: assert property (tx_valid_ff |-> busy_ff)
        else $error("byte sent while idle");
    AST_TX_READY: assert property (tx_valid_ff |-> $past(tx_ready))
        else $error("byte sent while engine busy");
    AST_TX_GAP: assert property (tx_valid_ff |=> !tx_valid_ff)
        else $error("bytes closer than two cycles");
    AST_WAIT: assert property (tx_valid_ff |->
        gap_ff >= response_wait_time_setting * 24'd10000)
        else $error("answer before response wait");
    AST_RTS_SEND: assert property (tx_valid_ff |-> rts_ff)
        else $error("rts low while sending");
    AST_RTS_ALWAYS: assert property ((!sel)[*3] |-> rts_ff)
        else $error("rts low with control off");
    AST_RTS_IDLE: assert property ((sel && !busy_ff)[*3] |-> !rts_ff)
        else $error("rts high while idle");
    AST_WR_BUSY: assert property (reg_wr_ff |-> busy_ff && !tx_valid_ff)
        else $error("write outside execution");
    AST_WR_STEP: assert property (reg_wr_ff && $past(reg_wr_ff) |->
        reg_addr_ff == $past(reg_addr_ff) + 16'h1)
        else $error("write address not successive");
endmodule // serial_slave_message_handler_checker

bind serial_slave_message_handler serial_slave_message_handler_checker chk_i (
    .clk(clk), .rst_n(rst_n), .frame_end(frame_end), .tx_ready(tx_ready),
    .transmit_enable_control_select(transmit_enable_control_select),
    .response_wait_time_setting(response_wait_time_setting),
    .tx_valid_ff(tx_valid_ff), .rts_ff(rts_ff), .reg_addr_ff(reg_addr_ff),
    .reg_wr_ff(reg_wr_ff), .busy_ff(busy_ff));

// ### dv/serial_slave_message_handler_tb.sv
// Self-checking bench for the serial slave message handler
`timescale 1ns/1ps
module serial_slave_message_handler_tb;
    reg         clk   = 1'b0;
    reg         rst_n = 1'b0;
    reg  [7:0]  own   = 8'h00;
    reg         sel   = 1'b0;
    reg         slow  = 1'b0;
    reg  [6:0]  wait_ms = 7'd1;
    reg  [15:0] tbl [0:63];
    reg  [7:0]  frm [0:40];
    wire [7:0]  rx_byte, tx_byte;
    wire        rx_valid, rx_error, frame_end, tx_ready;
    wire        tx_valid, rts, busy, reg_wr;
    wire [15:0] reg_addr, reg_wr_data;
    integer     bad_count = 0, compares = 0, cyc = 0, base = 0, i;
    initial forever #50 clk = ~clk;
    // Wait of 1 ms keeps the run short; the check scales with it
    serial_slave_message_handler uut (.clk(clk), .rst_n(rst_n),
        .clk_en(1'b1), .own_address(own), .response_wait_time_setting(wait_ms),
        .transmit_enable_control_select(sel), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_error(rx_error), .frame_end(frame_end),
        .tx_ready(tx_ready), .reg_rd_data(tbl[reg_addr[5:0]]),
        .tx_byte_ff(tx_byte), .tx_valid_ff(tx_valid), .rts_ff(rts),
        .reg_addr_ff(reg_addr), .reg_wr_data_ff(reg_wr_data),
        .reg_wr_ff(reg_wr), .busy_ff(busy));
    master_model mm (.clk(clk), .slow(slow), .tx_byte_ff(tx_byte),
        .tx_valid_ff(tx_valid), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_error(rx_error), .frame_end(frame_end), .tx_ready(tx_ready));
    always @(posedge clk) if (reg_wr === 1'b1) tbl[reg_addr[5:0]] <= reg_wr_data;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 95000) begin
            bad_count = bad_count + 1;
            complete_run;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        begin
            if (bad_count == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task chk(input string what, input [15:0] want, input [15:0] seen);
        begin
            compares = compares + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0s expected %h seen %h", what, want, seen);
            end
        end
    endtask
    task put(input [103:0] v, input integer n);
        for (i = 0; i < n; i = i + 1) frm[i] = v[8 * (n - 1 - i) +: 8];
    endtask
    task seal(input integer n); // Low byte of the remainder goes first
        integer k, b;
        reg [15:0] c;
        begin
            c = 16'hffff;
            for (k = 0; k < n; k = k + 1) begin
                c = c ^ frm[k];
                for (b = 0; b < 8; b = b + 1)
                    c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
            end
            frm[n] = c[7:0];
            frm[n + 1] = c[15:8];
        end
    endtask
    task go(input integer n, input flt);
        begin
            for (i = 0; i < n; i = i + 1) mm.cmd[i] = frm[i];
            mm.send(n, flt);
        end
    endtask
    task setup(input [7:0] o, input s, input w);
        begin
            @(posedge clk);
            own  <= o;
            sel  <= s;
            slow <= w;
            base = mm.rsp_n;
        end
    endtask
    task got(input integer n); // Compares the whole answer with frm
        begin
            while (mm.rsp_n < base + n) @(posedge clk);
            while (busy !== 1'b0) @(posedge clk);
            repeat (4) @(posedge clk);
            chk("length", n, mm.rsp_n - base);
            for (i = 0; i < n; i = i + 1) chk("byte", frm[i], mm.rsp[base + i]);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_drop_loop;
        begin
            setup(8'h01, 1'b1, 1'b1);
            put(104'h030812_34a537, 6);
            seal(6);
            go(8, 1'b0);
            repeat (200) @(posedge clk);
            put(104'h010812_34a537, 6);
            seal(6);
            frm[7] = ~frm[7];
            go(8, 1'b0);
            repeat (200) @(posedge clk);
            seal(6);
            go(8, 1'b1);
            repeat (200) @(posedge clk);
            go(8, 1'b0);
            got(8);
        end
    endtask
    task t_read;
        begin
            setup(8'h02, 1'b0, 1'b0);
            put(104'h02030020000445f0, 8);
            go(8, 1'b0);
            put(104'h02030800650000000001f4af82, 13);
            got(13);
        end
    endtask
    task t_write;
        begin
            setup(8'h01, 1'b0, 1'b0);
            wait_ms <= 7'd2;
            put(104'h01100001000204000102586339, 13);
            go(13, 1'b0);
            put(104'h0110000100021008, 8);
            got(8);
            chk("reg 1", 16'h0001, tbl[1]);
            chk("reg 2", 16'h0258, tbl[2]);
            wait_ms <= 7'd1;
        end
    endtask
    task t_err(input [7:0] fn, input [15:0] qty, input [7:0] code);
        begin
            setup(8'h01, 1'b0, 1'b0);
            put({8'h01, fn, 16'h0020, qty}, 6);
            seal(6);
            go(8, 1'b0);
            put({8'h01, fn | 8'h80, code}, 3);
            seal(3);
            got(5);
        end
    endtask
    task t_bcast; // Longest write, to every slave at once
        begin
            setup(8'h01, 1'b1, 1'b0);
            put(104'h00100010001020, 7);
            for (i = 0; i < 16; i = i + 1) begin
                frm[7 + 2 * i] = 8'h12;
                frm[8 + 2 * i] = i[7:0];
            end
            seal(39);
            go(41, 1'b0);
            repeat (12000) @(posedge clk);
            chk("no answer", 16'h0, mm.rsp_n - base);
            for (i = 0; i < 16; i = i + 1)
                chk("reg", {8'h12, i[7:0]}, tbl[16 + i]);
        end
    endtask
    initial begin
        for (i = 0; i < 64; i = i + 1) tbl[i] = 16'h0;
        tbl[32] = 16'h0065;
        tbl[35] = 16'h01f4;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_drop_loop;
        t_read;
        t_write;
        t_err(8'h04, 16'h0001, 8'h01);
        t_err(8'h03, 16'h0011, 8'h02);
        t_err(8'h03, 16'h0000, 8'h02);
        t_bcast;
        complete_run;
    end
endmodule // serial_slave_message_handler_tb

// ### src/crc16_step.v
// Byte-wide CRC-16 update, reflected form of polynomial 0x18005
`timescale 1ns/1ps
`include "msg_handler_map.vh"
module crc16_step (
    input  wire [15:0] crc_in,   // Running remainder
    input  wire [7:0]  data_in,  // Next frame byte
    output reg  [15:0] crc_out   // Updated remainder
);
    integer i;
    always @* begin
        crc_out = crc_in ^ {8'h00, data_in};
        for (i = 0; i < 8; i = i + 1) begin
            if (crc_out[0]) begin
                crc_out = (crc_out >> 1) ^ `CRC_POLY_REFL;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end
endmodule // crc16_step

// ### src/msg_handler_map.vh
// Constants for the serial slave message handler
`ifndef MSG_HANDLER_MAP_VH
`define MSG_HANDLER_MAP_VH

`define FN_READ        8'h03
`define FN_LOOPBACK    8'h08
`define FN_WRITE       8'h10
`define FN_ERR_BIT     8'h80
`define ADDR_BCAST     8'h00
`define ADDR_MAX       8'h20
`define QTY_MAX        8'h10
`define ERR_FUNC       8'h01
`define ERR_DATA       8'h02
`define ERR_LEN        8'h03
`define CRC_INIT       16'hffff
`define CRC_POLY_REFL  16'ha001
`define READ_CMD_LEN   6'd8
`define LOOP_CMD_LEN   6'd8
`define WR_HDR_LEN     6'd7
`define WR_MIN_LEN     6'd11
`define WR_MAX_LEN     6'd41
`define WR_RSP_LEN     6'd8
`define RD_RSP_MIN     6'd7
`define RD_RSP_MAX     6'd37
`define ERR_RSP_LEN    6'd5
`define BUF_DEPTH      41
`define CLK_HZ         10000000
`define WAIT_MS_MIN    5
`define WAIT_MS_MAX    65
`define WAIT_MS_RST    7'd5
`define CYC_PER_MS     (`CLK_HZ / 1000)

`endif

// ### src/serial_slave_message_handler.v
// Slave-side message interpreter for a multidrop MODBUS serial link
// Function
// - Transmit only in answer to a received command frame.
// - Own address 0..32 compared against first received byte.
// - Broadcast address zero executes but never answers.
// - Recognise function codes 03h read, 08h loopback, 10h write.
// - Read command 8 bytes; read answer 7 to 37 bytes.
// - Write command 11 to 41 bytes; normal answer 8 bytes.
// - CRC-16 over all preceding bytes, polynomial 1 1000 0000 0000 0101.
// - Read returns count consecutive registers; count at most 10h.
// - Read data high byte then low byte, ascending addresses.
// - Byte count equals twice register quantity.
// - Error answer: function with MSB set, error code, CRC.
// - Loopback returns the 8-byte command unchanged.
// - Write stores words into successive registers from start.
// - Eight data bits, one stop bit, selectable parity.
// - Bit rate one of five values, 1200 to 19200.
// - Response wait 5 to 65 ms after reception, default 5; the code uses any 0 to 127 ms setting as given, with no default.
// - RTS only while sending when enabled, else always on.
`timescale 1ns/1ps
`include "msg_handler_map.vh"
module serial_slave_message_handler (
    input  wire        clk,                     // 10 MHz system clock
    input  wire        rst_n,                   // Sync reset, active low
    input  wire        clk_en,                  // Freezes all state when low
    input  wire [7:0]  own_address,             // Slave address 0..32
    input  wire [6:0]  response_wait_time_setting, // Wait in ms
    input  wire        transmit_enable_control_select, // 1: RTS on send
    input  wire [7:0]  rx_byte,                 // Byte from UART engine
    input  wire        rx_valid,                // Byte strobe
    input  wire        rx_error,                // Parity/framing/overrun
    input  wire        frame_end,               // 3.5 char idle gap seen
    input  wire        tx_ready,                // UART engine can take byte
    input  wire [15:0] reg_rd_data,             // Data for reg_addr
    output reg  [7:0]  tx_byte_ff,              // Byte to UART engine
    output reg         tx_valid_ff,             // Byte strobe
    output reg         rts_ff,                  // Transmitter enable
    output reg  [15:0] reg_addr_ff,             // Data table address
    output reg  [15:0] reg_wr_data_ff,          // Write data
    output reg         reg_wr_ff,               // Write strobe
    output reg         busy_ff                  // Frame being handled
);
    ////////////////////////////////////////////////////////////////////////
    // One-hot states; the default branch recovers from any other code
    localparam [6:0] S_RX    = 7'b0000001;
    localparam [6:0] S_CHECK = 7'b0000010;
    localparam [6:0] S_EXEC  = 7'b0000100;
    localparam [6:0] S_WAIT  = 7'b0001000;
    localparam [6:0] S_FILL  = 7'b0010000;
    localparam [6:0] S_CRC   = 7'b0100000;
    localparam [6:0] S_SEND  = 7'b1000000;

    // Receive and answer bookkeeping
    reg [6:0]  state_ff;
    reg [7:0]  buf_ff [0:`BUF_DEPTH-1];
    reg [5:0]  rx_len_ff;
    reg        rx_bad_ff;
    reg [15:0] crc_ff;
    reg [5:0]  idx_ff;
    reg [5:0]  tx_len_ff;
    reg [4:0]  reg_cnt_ff;
    reg        bcast_ff;
    reg [23:0] wait_cnt_ff;
    reg        hi_ff;

    // One CRC byte step per cycle, shared by the check and the seal
    wire [15:0] nxt_crc;
    reg  [7:0]  crc_byte;
    crc16_step u_crc (
        .crc_in  (crc_ff),
        .data_in (crc_byte),
        .crc_out (nxt_crc)
    );

    wire [7:0]  fn      = buf_ff[1];
    wire [15:0] start   = {buf_ff[2], buf_ff[3]};
    wire [15:0] qty     = {buf_ff[4], buf_ff[5]};
    wire [15:0] rx_crc  = {buf_ff[rx_len_ff-6'd1], buf_ff[rx_len_ff-6'd2]};
    // Wait counts clocks, not characters: bit rate and parity live in
    // the shared bit engine, so any rate works here
    wire [31:0] wait_prod = response_wait_time_setting * `CYC_PER_MS;
    wire [23:0] wait_cyc  = wait_prod[23:0];        // 127 ms fits in 24 bits

    // Frame checks
    wire addr_match = (buf_ff[0] == own_address) &&
                      (own_address <= `ADDR_MAX);
    wire addr_ok    = addr_match || (buf_ff[0] == `ADDR_BCAST);
    wire fn_known   = (fn == `FN_READ) || (fn == `FN_LOOPBACK) ||
                      (fn == `FN_WRITE);
    // Six count bits: a 32-byte payload must still add up to 41
    wire len_ok     = (fn == `FN_WRITE) ?
                      (rx_len_ff >= `WR_MIN_LEN &&
                       rx_len_ff <= `WR_MAX_LEN &&
                       rx_len_ff == `WR_HDR_LEN + buf_ff[6][5:0] +
                       6'd2) :
                      (rx_len_ff == `READ_CMD_LEN);
    wire qty_ok     = (qty != 16'h0000) && (qty <= {8'h00, `QTY_MAX});
    wire cnt_ok     = (fn != `FN_WRITE) ||
                      ({8'h00, buf_ff[6]} == {qty[14:0], 1'b0});
    // Loopback fields are free, so its quantity bytes never earn an error
    wire err_cmd    = !(fn_known && qty_ok) &&
                      (fn != `FN_LOOPBACK);

    ////////////////////////////////////////////////////////////////////////
    always @* begin
        crc_byte = (state_ff == S_CRC || state_ff == S_CHECK) ?
                   buf_ff[idx_ff] : 8'h00;
    end

    // Answers are built in place over the command bytes, which saves a
    // second 41-byte store; a new frame waits until the send is over
    genvar g;
    generate
        for (g = 0; g < `BUF_DEPTH; g = g + 1) begin : g_buf
            always @(posedge clk) begin
                if (!rst_n) begin
                    buf_ff[g] <= 8'h00;
                end else if (clk_en) begin
                    if (state_ff == S_RX && rx_valid && rx_len_ff == g) begin
                        buf_ff[g] <= rx_byte;
                    end else if (state_ff == S_EXEC && g == 1 &&
                                 err_cmd) begin
                        buf_ff[g] <= fn | `FN_ERR_BIT;
                    end else if (state_ff == S_EXEC && g == 2 &&
                                 err_cmd) begin
                        buf_ff[g] <= fn_known ? `ERR_DATA : `ERR_FUNC;
                    end else if (state_ff == S_EXEC && fn == `FN_READ &&
                                 fn_known && qty_ok && g == 2) begin
                        buf_ff[g] <= {qty[6:0], 1'b0};
                    end else if (state_ff == S_FILL && idx_ff == g) begin
                        buf_ff[g] <= hi_ff ? reg_rd_data[15:8]
                                           : reg_rd_data[7:0];
                    end else if (state_ff == S_CRC && idx_ff == tx_len_ff &&
                                 g == tx_len_ff) begin
                        buf_ff[g] <= crc_ff[7:0];
                    end else if (state_ff == S_CRC && idx_ff == tx_len_ff &&
                                 g == tx_len_ff + 1) begin
                        buf_ff[g] <= crc_ff[15:8];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Control: receive, check, execute, wait, seal with CRC, send
    always @(posedge clk) begin
        if (!rst_n) begin
            state_ff       <= S_RX;
            rx_len_ff      <= 6'd0;
            rx_bad_ff      <= 1'b0;
            crc_ff         <= `CRC_INIT;
            idx_ff         <= 6'd0;
            tx_len_ff      <= 6'd0;
            reg_cnt_ff     <= 5'd0;
            bcast_ff       <= 1'b0;
            wait_cnt_ff    <= 24'h000000;
            hi_ff          <= 1'b1;
            tx_byte_ff     <= 8'h00;
            tx_valid_ff    <= 1'b0;
            // RTS idles high until the first enabled clock sees its mode
            rts_ff         <= 1'b1;
            reg_addr_ff    <= 16'h0000;
            reg_wr_data_ff <= 16'h0000;
            reg_wr_ff      <= 1'b0;
            busy_ff        <= 1'b0;
        end else if (clk_en) begin
            reg_wr_ff   <= 1'b0;
            tx_valid_ff <= 1'b0;
            // Follows the state one cycle late, in step with tx_valid_ff
            rts_ff      <= transmit_enable_control_select ?
                           (state_ff == S_SEND) : 1'b1;
            case (state_ff)
            S_RX: begin
                busy_ff <= 1'b0;
                if (rx_valid) begin
                    if (rx_len_ff < `BUF_DEPTH) begin
                        rx_len_ff <= rx_len_ff + 6'd1;
                    end else begin
                        rx_bad_ff <= 1'b1;                     // Overlong
                    end
                end
                if (rx_error) begin
                    rx_bad_ff <= 1'b1;
                end
                if (frame_end) begin
                    // A fault in the closing cycle still spoils the frame
                    if (rx_len_ff >= 6'd4 && !rx_bad_ff && !rx_error) begin
                        state_ff <= S_CHECK;
                        busy_ff  <= 1'b1;
                        idx_ff   <= 6'd0;
                        crc_ff   <= `CRC_INIT;
                    end else begin
                        rx_len_ff <= 6'd0;
                        rx_bad_ff <= 1'b0;
                    end
                end
            end
            S_CHECK: begin
                // Residue over body only; stored CRC compared after
                if (idx_ff == rx_len_ff - 6'd2) begin
                    if (crc_ff == rx_crc && addr_ok && len_ok &&
                        cnt_ok) begin
                        state_ff <= S_EXEC;
                        bcast_ff <= (buf_ff[0] == `ADDR_BCAST);
                        reg_addr_ff <= start;
                        reg_cnt_ff  <= 5'd0;
                        idx_ff      <= 6'd0;
                    end else begin
                        state_ff  <= S_RX;                    // Silently drop
                        rx_len_ff <= 6'd0;
                    end
                end else begin
                    crc_ff <= nxt_crc;
                    idx_ff <= idx_ff + 6'd1;
                end
            end
            S_EXEC: begin
                if (err_cmd) begin
                    tx_len_ff <= 6'd3;
                    state_ff  <= S_WAIT;
                end else if (fn == `FN_LOOPBACK) begin
                    tx_len_ff <= 6'd6;
                    state_ff  <= S_WAIT;
                end else if (fn == `FN_READ) begin
                    tx_len_ff <= 6'd3 + {qty[4:0], 1'b0};
                    idx_ff    <= 6'd3;
                    hi_ff     <= 1'b1;
                    state_ff  <= S_FILL;
                end else if (reg_cnt_ff == qty[4:0]) begin
                    tx_len_ff <= 6'd6;
                    state_ff  <= S_WAIT;
                end else begin
                    // One word per cycle until the count is reached
                    reg_wr_ff      <= 1'b1;
                    reg_wr_data_ff <= {buf_ff[7 + 2*reg_cnt_ff],
                                       buf_ff[8 + 2*reg_cnt_ff]};
                    reg_addr_ff    <= start + {11'h000, reg_cnt_ff};
                    reg_cnt_ff     <= reg_cnt_ff + 5'd1;
                end
                wait_cnt_ff <= 24'h000000;
            end
            S_FILL: begin
                // Read data is combinational on reg_addr_ff
                idx_ff <= idx_ff + 6'd1;
                hi_ff  <= ~hi_ff;
                if (!hi_ff) begin
                    reg_addr_ff <= reg_addr_ff + 16'h0001;
                end
                if (idx_ff == tx_len_ff - 6'd1) begin
                    state_ff <= S_WAIT;
                end
            end
            S_WAIT: begin
                // Counter was cleared in EXEC; broadcasts end here
                idx_ff <= 6'd0;
                crc_ff <= `CRC_INIT;
                if (wait_cnt_ff >= wait_cyc) begin
                    state_ff <= bcast_ff ? S_RX : S_CRC;
                    rx_len_ff <= 6'd0;
                end else begin
                    wait_cnt_ff <= wait_cnt_ff + 24'h000001;
                end
            end
            S_CRC: begin
                // Remainder over the answer body; low byte lands first
                if (idx_ff == tx_len_ff) begin
                    tx_len_ff <= tx_len_ff + 6'd2;
                    idx_ff    <= 6'd0;
                    state_ff  <= S_SEND;
                end else begin
                    crc_ff <= nxt_crc;
                    idx_ff <= idx_ff + 6'd1;
                end
            end
            S_SEND: begin
                // Only reached from a received command
                // One cycle without a strobe must pass before tx_ready is sampled again
                if (tx_ready && !tx_valid_ff) begin
                    if (idx_ff == tx_len_ff) begin
                        state_ff <= S_RX;
                        rx_len_ff <= 6'd0;
                    end else begin
                        tx_byte_ff  <= buf_ff[idx_ff];
                        tx_valid_ff <= 1'b1;
                        idx_ff      <= idx_ff + 6'd1;
                    end
                end
            end
            default: begin
                state_ff <= S_RX;
            end
            endcase
        end
    end
endmodule // serial_slave_message_handler
